// ### logic/acs_converter.sv
// converter end: conversion and calibration sequencer with output coding
//
// Behaviour
// R1: start conversions after calibration or from standby
// R2: convert held through calibration converts afterwards
// R3: channel select 00..11 picks input one..four
// R4: channel select latched on convert rising edge
// R5: undriven channel select reads as zero
// R6: bipolar adds half-scale offset; polarity unlatched
// R7: controller holds polarity 82 cycles before ready; the controller drives it straight from CTRL bit 4
// R8: controller changes polarity just after ready falls; it changes it whenever CTRL is written
// R9: from standby polarity may change with channel
// R10: every conversion result fully settled, none discarded
// R11: convert held high repeats 1622-cycle conversions
// R12: half-rate sequencing; standby start up to two late
// R13: standby start lowers ready 1624 cycles later
// R14: convert rising edge mid-conversion restarts conversion
// R15: straight binary unipolar, offset binary bipolar
// R16: results saturate at all ones and zero
// R17: offset step measures zero reference code
// R18: gain step measures full reference, stores span
// R19: channel and polarity ignored during calibration
// R20: bipolar reuses calibration, doubles step size
// R21: calibrate and convert both high starts calibration; during a conversion the code needs a convert rising edge as well
// R22: calibration 3246 cycles, then convert or standby
// R23: 1800-cycle wake-up before commands, then calibration or convert if requested, else standby
// R24: result word handed over as ready falls
`timescale 1ns/10ps
module acs_converter #(
  parameter int RES_W = acs_pkg::RESULT_WIDTH,
  parameter int RAW_W = acs_pkg::RAW_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  acs_link_if.device link,
  input wire logic [RAW_W-1:0] raw_density,
  output logic [1:0] mux_channel,
  output acs_pkg::acs_mod_sel_e modulator_input_sel,
  output acs_pkg::acs_state_e seq_state
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    acs_pkg::acs_state_e state;
    logic [11:0] cnt;
    logic phase;
    logic convert_request_q;
    logic [1:0] chan;
    logic first;
    logic [RAW_W-1:0] zero_code;
    logic [RAW_W-1:0] span;
    logic [RES_W-1:0] result;
    logic rdy_n;
    logic [3:0] rdy_cnt;
  } acs_convert_request_s;

  localparam int WIDE_W = RAW_W + RES_W + 2;
  localparam logic signed [WIDE_W-1:0] FULL_CODE = WIDE_W'((64'h1 << RES_W) - 64'h1);
  localparam logic signed [WIDE_W-1:0] HALF_CODE = WIDE_W'(64'h1 << (RES_W - 1));

  acs_convert_request_s state_reg;
  acs_convert_request_s state_next;

  logic convert_request_rise;
  logic cal_cmd;
  logic signed [WIDE_W-1:0] diff;
  logic signed [WIDE_W-1:0] divisor;
  logic signed [WIDE_W-1:0] scaled;
  logic [RES_W-1:0] coded;

  assign convert_request_rise = link.convert_request & ~state_reg.convert_request_q;
  assign cal_cmd = link.convert_request & link.calibrate_request;

  // ---------------------------------------------------------------
  // output coding from the calibrated span
  // ---------------------------------------------------------------
  always_comb begin
    diff = WIDE_W'($signed({1'b0, raw_density})) - WIDE_W'($signed({1'b0, state_reg.zero_code}));
    divisor = (state_reg.span == '0) ? WIDE_W'(1) : WIDE_W'($signed({1'b0, state_reg.span}));
    if (link.polarity_select) begin
      scaled = ((diff <<< (RES_W - 1)) / divisor) + HALF_CODE; // [R6] [R20]
    end else begin
      scaled = (diff <<< RES_W) / divisor; // [R15]
    end
    if (scaled < 0) begin
      coded = '0; // [R16]
    end else if (scaled > FULL_CODE) begin
      coded = FULL_CODE[RES_W-1:0]; // [R16]
    end else begin
      coded = scaled[RES_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.phase = ~state_reg.phase; // [R12]
    state_next.convert_request_q = link.convert_request;
    if (convert_request_rise) begin
      state_next.chan = {link.channel_msb_pin, link.channel_lsb_pin}; // [R4] [R5]
    end
    if (state_reg.rdy_cnt != 4'h0) begin
      state_next.rdy_cnt = state_reg.rdy_cnt - 4'h1;
      if (state_reg.rdy_cnt == 4'h1) begin
        state_next.rdy_n = 1'b1;
      end
    end
    case (state_reg.state)
      acs_pkg::ST_WAKE: begin
        state_next.cnt = state_reg.cnt + 12'h1;
        if (state_reg.cnt >= acs_pkg::WAKE_CYCLES) begin // [R23]
          state_next.cnt = 12'h1;
          if (cal_cmd) begin
            state_next.state = acs_pkg::ST_CAL_OFFSET;
          end else if (link.convert_request) begin
            state_next.state = acs_pkg::ST_ALIGN;
          end else begin
            state_next.state = acs_pkg::ST_STANDBY;
          end
        end
      end
      acs_pkg::ST_STANDBY: begin
        state_next.cnt = 12'h1;
        if (cal_cmd) begin
          state_next.state = acs_pkg::ST_CAL_OFFSET; // [R21]
        end else if (convert_request_rise) begin
          state_next.state = acs_pkg::ST_ALIGN; // [R1]
        end
      end
      acs_pkg::ST_ALIGN: begin
        state_next.cnt = 12'h1;
        if (cal_cmd) begin
          state_next.state = acs_pkg::ST_CAL_OFFSET;
        end else if (state_reg.phase) begin
          state_next.state = acs_pkg::ST_CONVERT; // [R12]
          state_next.first = 1'b1;
        end
      end
      acs_pkg::ST_CAL_OFFSET, acs_pkg::ST_CAL_GAIN: begin
        state_next.cnt = state_reg.cnt + 12'h1;
        if (convert_request_rise && link.calibrate_request) begin
          state_next.state = acs_pkg::ST_CAL_OFFSET;
          state_next.cnt = 12'h1;
        end else if (state_reg.cnt == acs_pkg::CAL_STEP_CYCLES
                     && state_reg.state == acs_pkg::ST_CAL_OFFSET) begin
          state_next.zero_code = raw_density; // [R17]
          state_next.state = acs_pkg::ST_CAL_GAIN;
        end else if (state_reg.cnt >= acs_pkg::CAL_CYCLES) begin // [R22]
          state_next.span = raw_density - state_reg.zero_code; // [R18]
          state_next.cnt = 12'h1;
          if (link.convert_request) begin
            state_next.state = acs_pkg::ST_CONVERT; // [R2] [R1]
            state_next.first = 1'b0;
          end else begin
            state_next.state = acs_pkg::ST_STANDBY;
          end
        end
      end
      acs_pkg::ST_CONVERT: begin
        state_next.cnt = state_reg.cnt + 12'h1;
        if (cal_cmd && convert_request_rise) begin
          state_next.state = acs_pkg::ST_CAL_OFFSET; // [R21]
          state_next.cnt = 12'h1;
        end else if (convert_request_rise) begin
          state_next.cnt = 12'h1; // [R14]
          state_next.first = 1'b0;
        end else if (state_reg.cnt >= (state_reg.first ? acs_pkg::CONVERT_REQUEST_FIRST_CYCLES
                                                        : acs_pkg::CONVERT_REQUEST_CYCLES)) begin // [R13] [R11]
          state_next.result = coded; // [R24] [R10]
          state_next.rdy_n = 1'b0;
          state_next.rdy_cnt = acs_pkg::READY_LOW_CYCLES;
          state_next.cnt = 12'h1;
          state_next.first = 1'b0;
          if (!link.convert_request) begin
            state_next.state = acs_pkg::ST_STANDBY;
          end
        end
      end
      default: begin
        state_next.state = acs_pkg::ST_STANDBY;
        state_next.cnt = 12'h1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{state: acs_pkg::ST_WAKE, cnt: 12'h1, phase: 1'b0, convert_request_q: 1'b0,
                     chan: 2'h0, first: 1'b0, zero_code: '0, span: '0, result: '0,
                     rdy_n: 1'b1, rdy_cnt: 4'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.result_ready_n = state_reg.rdy_n;
  assign link.result_word = state_reg.result; // [R24]
  assign seq_state = state_reg.state;

  always_comb begin
    mux_channel = state_reg.chan; // [R3]
    case (state_reg.state)
      acs_pkg::ST_CAL_OFFSET: begin
        modulator_input_sel = acs_pkg::MOD_ZERO_REF; // [R17] [R19]
        mux_channel = 2'h0;
      end
      acs_pkg::ST_CAL_GAIN: begin
        modulator_input_sel = acs_pkg::MOD_FULL_REF; // [R18] [R19]
        mux_channel = 2'h0;
      end
      default: begin
        modulator_input_sel = acs_pkg::MOD_SIGNAL;
      end
    endcase
  end

endmodule

// ### common/acs_pkg.sv
// package: timing counts, encodings and register map of the conversion sequencer
package acs_pkg;

  // ---------------------------------------------------------------
  // timing counts, in input clock cycles
  // ---------------------------------------------------------------
  localparam logic [11:0] WAKE_CYCLES = 12'h708;       // 1800
  localparam logic [11:0] CAL_CYCLES = 12'hCAE;        // 3246
  localparam logic [11:0] CAL_STEP_CYCLES = 12'h657;   // 1623, offset step
  localparam logic [11:0] CONVERT_REQUEST_CYCLES = 12'h656;       // 1622
  localparam logic [11:0] CONVERT_REQUEST_FIRST_CYCLES = 12'h658; // 1624
  localparam logic [11:0] POL_HOLD_CYCLES = 12'h052;   // 82
  localparam logic [3:0] READY_LOW_CYCLES = 4'h8;

  // ---------------------------------------------------------------
  // sequencer states and modulator input routing
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAKE,
    ST_STANDBY,
    ST_ALIGN,
    ST_CAL_OFFSET,
    ST_CAL_GAIN,
    ST_CONVERT
  } acs_state_e;

  typedef enum logic [1:0] {
    MOD_SIGNAL,
    MOD_ZERO_REF,
    MOD_FULL_REF
  } acs_mod_sel_e;

  // ---------------------------------------------------------------
  // controller register map (apb byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;
  localparam logic [7:0] COUNT_OFFSET = 8'h0C;

  localparam int CTRL_CONVERT_BIT = 0;
  localparam int CTRL_CALIBRATE_BIT = 1;
  localparam int CTRL_CHAN_LSB_BIT = 2;
  localparam int CTRL_CHAN_MSB_BIT = 3;
  localparam int CTRL_BIPOLAR_BIT = 4;
  localparam int CTRL_SEL_DRIVE_BIT = 5;
  localparam int STATUS_READY_BIT = 0;
  localparam int STATUS_NEW_BIT = 1;

  localparam logic [5:0] CTRL_RESET = 6'h20;
  localparam int RESULT_WIDTH = 20;
  localparam int RAW_WIDTH = 24;

endpackage

// ### common/acs_link_if.sv
// interface: control pins and result word between controller and converter
`timescale 1ns/10ps
interface acs_link_if #(
  parameter int RES_W = acs_pkg::RESULT_WIDTH
);
  logic convert_request;
  logic calibrate_request;
  logic channel_sel_msb;
  logic channel_sel_lsb;
  logic channel_sel_oe;
  logic polarity_select;
  logic result_ready_n;
  logic [RES_W-1:0] result_word;
  logic channel_msb_pin;
  logic channel_lsb_pin;

  // ---------------------------------------------------------------
  // pull-downs on undriven channel select
  // ---------------------------------------------------------------
  assign channel_msb_pin = channel_sel_oe & channel_sel_msb; // [R5]
  assign channel_lsb_pin = channel_sel_oe & channel_sel_lsb; // [R5]

  modport device (
    input convert_request,
    input calibrate_request,
    input channel_msb_pin,
    input channel_lsb_pin,
    input polarity_select,
    output result_ready_n,
    output result_word
  );

  modport host (
    output convert_request,
    output calibrate_request,
    output channel_sel_msb,
    output channel_sel_lsb,
    output channel_sel_oe,
    output polarity_select,
    input result_ready_n,
    input result_word
  );
endinterface

// ### logic/acs_controller.sv
// controller end: apb registers driving the converter control pins
`timescale 1ns/10ps
module acs_controller #(
  parameter int RES_W = acs_pkg::RESULT_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  acs_link_if.host link
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0] ctrl;
    logic new_result;
    logic rdy_q;
    logic [RES_W-1:0] result;
    logic [15:0] count;
    logic [31:0] rdata;
    logic err;
  } acs_ctrl_s;

  acs_ctrl_s state_reg;
  acs_ctrl_s state_next;
  logic access;
  logic ready_fall;
  logic mapped;

  assign access = psel & penable;
  assign ready_fall = state_reg.rdy_q & ~link.result_ready_n;
  assign mapped = paddr == acs_pkg::CTRL_OFFSET || paddr == acs_pkg::STATUS_OFFSET
                  || paddr == acs_pkg::RESULT_OFFSET || paddr == acs_pkg::COUNT_OFFSET;

  // ---------------------------------------------------------------
  // register access and result capture
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdy_q = link.result_ready_n;
    state_next.err = 1'b0;
    if (ready_fall) begin
      state_next.result = link.result_word;
      state_next.count = state_reg.count + 16'h1;
    end
    if (psel && !penable) begin
      state_next.err = ~mapped;
      case (paddr)
        acs_pkg::CTRL_OFFSET: state_next.rdata = {26'h0, state_reg.ctrl};
        acs_pkg::STATUS_OFFSET: state_next.rdata = {30'h0, state_reg.new_result,
                                                    ~link.result_ready_n};
        acs_pkg::RESULT_OFFSET: state_next.rdata = 32'(state_reg.result);
        acs_pkg::COUNT_OFFSET: state_next.rdata = {16'h0, state_reg.count};
        default: state_next.rdata = 32'h0;
      endcase
    end
    if (access && pwrite) begin
      if (paddr == acs_pkg::CTRL_OFFSET) begin
        state_next.ctrl = pwdata[5:0];
      end
      if (paddr == acs_pkg::STATUS_OFFSET && pwdata[acs_pkg::STATUS_NEW_BIT]) begin
        state_next.new_result = 1'b0;
      end
    end
    if (ready_fall) begin
      state_next.new_result = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{ctrl: acs_pkg::CTRL_RESET, new_result: 1'b0, rdy_q: 1'b1,
                     result: '0, count: 16'h0, rdata: 32'h0, err: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = state_reg.rdata;
  assign pslverr = access & state_reg.err;
  assign link.convert_request = state_reg.ctrl[acs_pkg::CTRL_CONVERT_BIT];
  assign link.calibrate_request = state_reg.ctrl[acs_pkg::CTRL_CALIBRATE_BIT];
  assign link.channel_sel_lsb = state_reg.ctrl[acs_pkg::CTRL_CHAN_LSB_BIT]; // [R9]
  assign link.channel_sel_msb = state_reg.ctrl[acs_pkg::CTRL_CHAN_MSB_BIT];
  assign link.channel_sel_oe = state_reg.ctrl[acs_pkg::CTRL_SEL_DRIVE_BIT];
  assign link.polarity_select = state_reg.ctrl[acs_pkg::CTRL_BIPOLAR_BIT]; // [R7] [R8]

endmodule

// ### bench/acs_link_asserts.sv
// checker: sequencer timing and routing relations on the link
`timescale 1ns/10ps
module acs_link_asserts #(
  parameter int RES_W = acs_pkg::RESULT_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic convert_request,
  input wire logic calibrate_request,
  input wire logic channel_msb_pin,
  input wire logic channel_lsb_pin,
  input wire logic result_ready_n,
  input wire logic [RES_W-1:0] result_word,
  input wire logic [1:0] mux_channel,
  input wire acs_pkg::acs_mod_sel_e modulator_input_sel,
  input wire acs_pkg::acs_state_e seq_state
);
  // ----------
  // helper counters
  // ----------
  logic [11:0] age, n, c;
  logic first, rs, rd, cv, cal_now;
  acs_pkg::acs_state_e prev;
  assign cal_now = seq_state inside {acs_pkg::ST_CAL_OFFSET, acs_pkg::ST_CAL_GAIN};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age <= '0;
      n <= '0;
      c <= '0;
      first <= 1'b0;
      rs <= 1'b0;
      rd <= 1'b1;
      cv <= 1'b0;
      prev <= acs_pkg::ST_WAKE;
    end else begin
      age <= (age == 12'hFFF) ? age : age + 12'h001;
      c <= cal_now ? c + 12'h001 : 12'h000;
      rd <= result_ready_n;
      cv <= convert_request;
      prev <= seq_state;
      n <= n + 12'h001;
      if (seq_state == acs_pkg::ST_CONVERT && prev != acs_pkg::ST_CONVERT) begin
        n <= 12'h001;
        first <= (prev == acs_pkg::ST_ALIGN);
        rs <= 1'b0;
      end else if (rd && !result_ready_n) begin
        n <= 12'h001;
        first <= 1'b0;
        rs <= 1'b0;
      end
      if (convert_request && !cv && seq_state == acs_pkg::ST_CONVERT) begin
        rs <= 1'b1;
      end
    end
  end
  // ----------
  // properties
  // ----------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wake_hold_a: assert property (age < 12'd1799 |-> seq_state == acs_pkg::ST_WAKE)
    else $error("left wake-up too early");
  wake_end_a: assert property (age == 12'd1803 |-> seq_state != acs_pkg::ST_WAKE)
    else $error("still in wake-up");
  first_len_a: assert property ($fell(result_ready_n) && first && !rs |-> n == 12'd1624)
    else $error("standby start length wrong");
  cont_len_a: assert property ($fell(result_ready_n) && !first && !rs |-> n == 12'd1622)
    else $error("conversion length wrong");
  cal_len_a: assert property ($past(cal_now) && !cal_now |-> c == 12'd3246)
    else $error("calibration length wrong");
  cal_exit_a: assert property ($past(cal_now) && !cal_now |-> seq_state ==
    ($past(convert_request) ? acs_pkg::ST_CONVERT : acs_pkg::ST_STANDBY))
    else $error("wrong state after calibration");
  offset_route_a: assert property (seq_state == acs_pkg::ST_CAL_OFFSET |->
    modulator_input_sel == acs_pkg::MOD_ZERO_REF && mux_channel == 2'h0)
    else $error("offset step routing wrong");
  gain_route_a: assert property (seq_state == acs_pkg::ST_CAL_GAIN |->
    modulator_input_sel == acs_pkg::MOD_FULL_REF)
    else $error("gain step routing wrong");
  chan_latch_a: assert property ($rose(convert_request) && !calibrate_request &&
    seq_state inside {acs_pkg::ST_STANDBY, acs_pkg::ST_CONVERT}
    |=> mux_channel == $past({channel_msb_pin, channel_lsb_pin}))
    else $error("channel not latched");
  word_move_a: assert property (!$stable(result_word) |-> $fell(result_ready_n))
    else $error("result moved without ready");
  ready_low_a: assert property ($fell(result_ready_n) |=>
    !result_ready_n [*7] ##1 result_ready_n)
    else $error("ready low time wrong");
  cal_entry_a: assert property (seq_state == acs_pkg::ST_STANDBY && convert_request &&
    calibrate_request |-> ##[1:3] seq_state == acs_pkg::ST_CAL_OFFSET)
    else $error("calibration not entered");
  cover property (seq_state == acs_pkg::ST_CAL_GAIN ##1 seq_state == acs_pkg::ST_CONVERT);
  cover property ($fell(result_ready_n) && rs);
  cover property ($fell(result_ready_n) && first);
endmodule

// ### bench/adc_conversion_sequencer_bench.sv
// testbench: controller and converter joined over the link
`timescale 1ns/10ps
module adc_conversion_sequencer_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] raw_density, sig;
  logic [1:0] mux_channel;
  acs_pkg::acs_mod_sel_e msel;
  acs_pkg::acs_state_e seq_state;
  int n_mismatch, total_checks;
  acs_link_if link();
  acs_controller acs_controller_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  acs_converter acs_converter_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .raw_density(raw_density), .mux_channel(mux_channel), .modulator_input_sel(msel),
    .seq_state(seq_state));
  acs_link_asserts acs_link_asserts_inst (.pclk(pclk), .presetn(presetn),
    .convert_request(link.convert_request), .calibrate_request(link.calibrate_request),
    .channel_msb_pin(link.channel_msb_pin), .channel_lsb_pin(link.channel_lsb_pin),
    .result_ready_n(link.result_ready_n), .result_word(link.result_word),
    .mux_channel(mux_channel), .modulator_input_sel(msel), .seq_state(seq_state));
  // ----------
  // shared tasks
  // ----------
  always @(posedge pclk) begin
    case (msel)
      acs_pkg::MOD_ZERO_REF: raw_density <= 24'h100000;
      acs_pkg::MOD_FULL_REF: raw_density <= 24'h200000;
      default: raw_density <= sig;
    endcase
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, acs_pkg::CTRL_OFFSET, d, q, e);
  endtask
  task automatic wait_fall(output int cyc);
    cyc = 0;
    while (link.result_ready_n !== 1'b0 && cyc < 6000) begin
      @(negedge pclk);
      cyc++;
    end
    if (cyc >= 6000) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic stop;
    int k;
    wr(32'h20);
    k = 0;
    while (seq_state !== acs_pkg::ST_STANDBY && k < 4000) begin
      @(negedge pclk);
      k++;
    end
    if (k >= 4000) begin
      n_mismatch++;
      summarize();
    end
    repeat (12) @(posedge pclk);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    apb(1'b0, acs_pkg::CTRL_OFFSET, 32'h0, q, e);
    chk(q, 32'h20);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b0, acs_pkg::STATUS_OFFSET, 32'h0, q, e);
    chk(q, 32'h0);
    chk(32'(link.result_ready_n), 32'h1);
    stop();
    $display("test reset done");
  endtask
  task automatic t_cal;
    logic [31:0] q;
    logic e;
    int cyc;
    logic [47:0] tbl [3] = '{48'h1_112345_891A2, 48'h0_300000_FFFFF, 48'h0_0A0000_00000};
    sig <= 24'h112345;
    wr(32'h23);
    wr(32'h21);
    wait_fall(cyc);
    chk(32'(link.result_word), 32'h12345);
    apb(1'b0, acs_pkg::RESULT_OFFSET, 32'h0, q, e);
    chk(q, 32'h12345);
    apb(1'b0, acs_pkg::COUNT_OFFSET, 32'h0, q, e);
    chk(q, 32'h1);
    apb(1'b0, acs_pkg::STATUS_OFFSET, 32'h0, q, e);
    chk(q & 32'h2, 32'h2);
    apb(1'b1, acs_pkg::STATUS_OFFSET, 32'h2, q, e);
    repeat (10) @(posedge pclk);
    apb(1'b0, acs_pkg::STATUS_OFFSET, 32'h0, q, e);
    chk(q, 32'h0);
    foreach (tbl[i]) begin
      repeat (10) @(posedge pclk);
      wr(32'h21 | (32'(tbl[i][44]) << 4));
      sig <= tbl[i][43:20];
      wait_fall(cyc);
      chk(32'(link.result_word), 32'(tbl[i][19:0]));
    end
    stop();
    $display("test calibration done");
  endtask
  task automatic t_chan;
    int cyc;
    logic [31:0] c;
    sig <= 24'h112345;
    for (int ch = 0; ch < 4; ch++) begin
      c = 32'h20 | (32'(ch) << 2) | (32'(ch % 2) << 4);
      wr(c);
      wr(c | 32'h1);
      wait_fall(cyc);
      chk(32'(cyc >= 1624 && cyc <= 1628), 32'h1);
      chk(32'(mux_channel), 32'(ch));
      chk(32'(link.result_word), (ch % 2) ? 32'h891A2 : 32'h12345);
      stop();
    end
    wr(32'h0C);
    wr(32'h0D);
    repeat (4) @(negedge pclk);
    chk(32'(mux_channel), 32'h0);
    stop();
    $display("test channels done");
  endtask
  task automatic t_restart;
    int cyc;
    wr(32'h21);
    repeat (800) @(posedge pclk);
    wr(32'h20);
    wr(32'h21);
    wait_fall(cyc);
    chk(32'(cyc >= 1620 && cyc <= 1628), 32'h1);
    stop();
    $display("test restart done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sig = 24'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cal();
    t_chan();
    t_restart();
    summarize();
  end
endmodule
